// file: src/ccc_pkg.sv
package ccc_pkg;

	localparam int CCC_ADDR_W = 8;
	localparam int CCC_HALF_W = 16;
	localparam int CCC_FULL_W = 32;

	localparam logic [7:0] CCC_OFS_CTRL2 = 8'h00;
	localparam logic [7:0] CCC_OFS_CTRL1 = 8'h04;
	localparam logic [7:0] CCC_OFS_PRIMARY = 8'h08;
	localparam logic [7:0] CCC_OFS_SECONDARY = 8'h0C;
	localparam logic [7:0] CCC_OFS_PERIOD = 8'h10;
	localparam logic [7:0] CCC_OFS_COUNTER = 8'h14;
	localparam logic [7:0] CCC_OFS_IRQ_STATUS = 8'h18;
	localparam logic [7:0] CCC_OFS_IRQ_MASK = 8'h1C;

	localparam logic [15:0] CCC_CTRL2_RESET = 16'h000C;
	localparam logic [31:0] CCC_WORD_RESET = 32'h00000000;
	localparam logic [15:0] CCC_PERIOD_RESET = 16'hFFFF;

	localparam int CCC_C1_MODE_POS = 0;
	localparam int CCC_C1_AUTOCLR_POS = 3;
	localparam int CCC_C1_FAULT_EN_POS = 4;
	localparam int CCC_C1_FAULT_FLAG_POS = 5;
	localparam int CCC_C1_FAULT_CLR_POS = 8;

	localparam int CCC_IRQ_W = 4;
	localparam int CCC_IRQ_MATCH = 0;
	localparam int CCC_IRQ_PERIOD = 1;
	localparam int CCC_IRQ_FAULT = 2;
	localparam int CCC_IRQ_TRIGGER = 3;

	localparam logic [2:0] CCC_MODE_OFF = 3'h0;
	localparam logic [2:0] CCC_MODE_SS_HIGH = 3'h1;
	localparam logic [2:0] CCC_MODE_SS_LOW = 3'h2;
	localparam logic [2:0] CCC_MODE_TOGGLE = 3'h3;
	localparam logic [2:0] CCC_MODE_DUAL_SS = 3'h4;
	localparam logic [2:0] CCC_MODE_DUAL_CONT = 3'h5;
	localparam logic [2:0] CCC_MODE_PWM_EDGE = 3'h6;
	localparam logic [2:0] CCC_MODE_PWM_CENTER = 3'h7;

	localparam logic [4:0] CCC_SRC_NONE = 5'h00;
	localparam logic [4:0] CCC_SRC_CMP_LO = 5'h01;
	localparam logic [4:0] CCC_SRC_CMP_HI = 5'h05;
	localparam logic [4:0] CCC_SRC_CAP5 = 5'h0A;
	localparam logic [4:0] CCC_SRC_TMR_LO = 5'h0B;
	localparam logic [4:0] CCC_SRC_TMR_HI = 5'h0F;
	localparam logic [4:0] CCC_SRC_CAP_LO = 5'h14;
	localparam logic [4:0] CCC_SRC_ANALOG_HI = 5'h1C;
	localparam logic [4:0] CCC_SRC_SELF = 5'h1F;

	localparam logic [1:0] CCC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCC_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic fault_hold_select;
		logic fault_drive_level;
		logic fault_force_drive;
		logic output_invert;
		logic reserved_11;
		logic [1:0] edge_fine_delay;
		logic cascade_pair_enable;
		logic trigger_not_sync_select;
		logic trigger_running_flag;
		logic pin_float_select;
		logic [4:0] source_select;
	} ccc_ctrl2_type;

	typedef struct packed {
		logic [CCC_ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} ccc_wr_type;

endpackage : ccc_pkg

// file: src/ccc_fine_edge.sv
module ccc_fine_edge
	import ccc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic level_in,
	input wire logic [1:0] delay_code,
	output logic level_out,
	output logic [1:0] phase_out
);

	logic prev_reg;
	logic prev_next;
	logic level_reg;
	logic level_next;
	logic [1:0] phase_reg;
	logic [1:0] phase_next;

	// falling edge held one cycle longer, phase says how many quarters in it falls
	always_comb begin
		prev_next = level_in;
		level_next = level_in;
		phase_next = 2'h0;
		if (prev_reg && !level_in && delay_code != 2'h0) begin
			level_next = 1'b1;
			phase_next = delay_code;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_reg <= 1'b0;
			level_reg <= 1'b0;
			phase_reg <= 2'h0;
		end else begin
			prev_reg <= prev_next;
			level_reg <= level_next;
			phase_reg <= phase_next;
		end
	end

	assign level_out = level_reg;
	assign phase_out = phase_reg;

endmodule : ccc_fine_edge

// file: src/ccc_channel.sv
// Summary of operation
// - hold select 1: fault lasts until input gone and, in center PWM mode, software clears fault flag
// - hold select 0: fault lasts until input gone and a new period starts
// - during fault the pin shows the fault drive level bit
// - force drive 1 enables the pin driver during fault; 0 leaves direction alone
// - invert bit flips the compare output
// - fine delay code postpones falling edge by 0, 1/4, 1/2 or 3/4 cycle
// - inverted output delays rising edge instead; mode 001 ignores the delay
// - cascade bit joins two halves into one 32-bit counter and compare
// - trigger select 1 means triggered by source, 0 means synchronised to it
// - running flag set by hardware on trigger; counter held zero while clear if trigger select 1
// - float bit releases the pin driver; otherwise the channel drives it
// - source codes: 0 none, 1-5 compare channels, 11-15 timers
// - capture, comparator, converter and charge-time codes act only as triggers
// - autoclear bit clears running flag on secondary match; software may clear too
// - fault flag used only in center PWM mode, cleared by software (hold select 1) or at period start (hold select 0)
// - fine delay field double buffered in PWM modes, loaded at period start
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
module ccc_channel
	import ccc_pkg::*;
#(
	parameter logic [4:0] SELF_CODE = 5'h01
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CCC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [CCC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] source_events,
	input wire logic fault_a_in,
	output logic compare_output_pin_out,
	output logic compare_output_pin_oe,
	output logic [1:0] edge_phase,
	output logic period_event,
	output logic irq
);

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_strb

	function automatic logic sync_ok(input logic [4:0] code);
		return code != SELF_CODE && ((code >= CCC_SRC_CMP_LO && code <= CCC_SRC_CMP_HI)
			|| (code >= CCC_SRC_TMR_LO && code <= CCC_SRC_TMR_HI));
	endfunction : sync_ok

	function automatic logic trig_ok(input logic [4:0] code);
		return sync_ok(code) || code == CCC_SRC_CAP5
			|| (code >= CCC_SRC_CAP_LO && code <= CCC_SRC_ANALOG_HI);
	endfunction : trig_ok

	function automatic logic is_mapped(input logic [CCC_ADDR_W-1:0] a);
		return a == CCC_OFS_CTRL2 || a == CCC_OFS_CTRL1 || a == CCC_OFS_PRIMARY || a == CCC_OFS_SECONDARY
			|| a == CCC_OFS_PERIOD || a == CCC_OFS_COUNTER || a == CCC_OFS_IRQ_STATUS || a == CCC_OFS_IRQ_MASK;
	endfunction : is_mapped

	// bus state
	ccc_wr_type wr_reg, wr_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_en;

	// core state
	ccc_ctrl2_type ctrl2_reg, ctrl2_next;
	logic [2:0] mode_reg, mode_next, mode_seen_reg, mode_seen_next;
	logic autoclr_reg, autoclr_next, fault_en_reg, fault_en_next;
	logic [31:0] primary_reg, primary_next, secondary_reg, secondary_next, period_reg, period_next;
	logic [31:0] cnt_reg, cnt_next;
	logic raw_reg, raw_next, done_reg, done_next;
	logic fault_active_reg, fault_active_next, fault_flag_reg, fault_flag_next;
	logic [1:0] delay_act_reg, delay_act_next;
	logic [CCC_IRQ_W-1:0] irq_status_reg, irq_status_next, irq_mask_reg, irq_mask_next;
	logic pin_reg, pin_next, oe_reg, oe_next, irq_reg, irq_next, period_ev_reg, period_ev_next;
	logic [1:0] phase_reg, phase_next;

	logic [31:0] mask, cnt_m, pri_m, sec_m, per_m, wval;
	logic pwm, sel_event, hold_zero, sync_hit, wrap, period_start, match_p, match_s;
	logic trig_set, fault_cond, fault_clr_wr, fine_level;
	logic [1:0] fine_phase, delay_eff;
	logic [CCC_IRQ_W-1:0] events;

	always_comb begin
		wr_next = wr_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		wr_en = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			aw_have_next = 1'b1;
			wr_next.addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_have_next = 1'b1;
			wr_next.data = s_axi_wdata;
			wr_next.strb = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (aw_have_reg && w_have_reg && !bvalid_reg) begin
			wr_en = is_mapped(wr_reg.addr);
			bresp_next = is_mapped(wr_reg.addr) ? CCC_RESP_OKAY : CCC_RESP_SLVERR;
			bvalid_next = 1'b1;
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
		end
		awready_next = !aw_have_next && !bvalid_next;
		wready_next = !w_have_next && !bvalid_next;
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = is_mapped(s_axi_araddr) ? CCC_RESP_OKAY : CCC_RESP_SLVERR;
			case (s_axi_araddr)
				CCC_OFS_CTRL2: rdata_next = {16'h0000, ctrl2_reg};
				CCC_OFS_CTRL1: rdata_next = {23'h000000, 3'h0, fault_flag_reg, fault_en_reg, autoclr_reg, mode_reg};
				CCC_OFS_PRIMARY: rdata_next = primary_reg;
				CCC_OFS_SECONDARY: rdata_next = secondary_reg;
				CCC_OFS_PERIOD: rdata_next = period_reg;
				CCC_OFS_COUNTER: rdata_next = cnt_reg;
				CCC_OFS_IRQ_STATUS: rdata_next = {28'h0000000, irq_status_reg};
				CCC_OFS_IRQ_MASK: rdata_next = {28'h0000000, irq_mask_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
		arready_next = !rvalid_next;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_reg <= '0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= CCC_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= CCC_RESP_OKAY;
			rdata_reg <= CCC_WORD_RESET;
		end else begin
			wr_reg <= wr_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	ccc_fine_edge u_fine (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(raw_reg),
		.delay_code(delay_eff),
		.level_out(fine_level),
		.phase_out(fine_phase)
	);

	always_comb begin
		ctrl2_next = ctrl2_reg;
		mode_next = mode_reg;
		autoclr_next = autoclr_reg;
		fault_en_next = fault_en_reg;
		primary_next = primary_reg;
		secondary_next = secondary_reg;
		period_next = period_reg;
		irq_mask_next = irq_mask_reg;
		fault_clr_wr = 1'b0;
		wval = merge_strb(CCC_WORD_RESET, wr_reg.data, wr_reg.strb);
		// software writes
		if (wr_en) begin
			case (wr_reg.addr)
				CCC_OFS_CTRL2: begin
					ctrl2_next = ccc_ctrl2_type'(merge_strb({16'h0000, ctrl2_reg}, wr_reg.data, wr_reg.strb));
					ctrl2_next.reserved_11 = 1'b0;
				end
				CCC_OFS_CTRL1: begin
					if (wr_reg.strb[0]) begin
						mode_next = wr_reg.data[CCC_C1_MODE_POS +: 3];
						autoclr_next = wr_reg.data[CCC_C1_AUTOCLR_POS];
						fault_en_next = wr_reg.data[CCC_C1_FAULT_EN_POS];
					end
					fault_clr_wr = wr_reg.strb[1] && wr_reg.data[CCC_C1_FAULT_CLR_POS];
				end
				CCC_OFS_PRIMARY: primary_next = merge_strb(primary_reg, wr_reg.data, wr_reg.strb);
				CCC_OFS_SECONDARY: secondary_next = merge_strb(secondary_reg, wr_reg.data, wr_reg.strb);
				CCC_OFS_PERIOD: period_next = merge_strb(period_reg, wr_reg.data, wr_reg.strb);
				CCC_OFS_IRQ_MASK: irq_mask_next = wval[CCC_IRQ_W-1:0];
				default: ;
			endcase
		end
		mask = ctrl2_reg.cascade_pair_enable ? 32'hFFFFFFFF : 32'h0000FFFF;
		cnt_m = cnt_reg & mask;
		pri_m = primary_reg & mask;
		sec_m = secondary_reg & mask;
		per_m = period_reg & mask;
		pwm = mode_reg == CCC_MODE_PWM_EDGE || mode_reg == CCC_MODE_PWM_CENTER;
		// self code and unlisted codes select nothing
		sel_event = trig_ok(ctrl2_reg.source_select) && source_events[ctrl2_reg.source_select];
		hold_zero = ctrl2_reg.trigger_not_sync_select && !ctrl2_reg.trigger_running_flag;
		sync_hit = !ctrl2_reg.trigger_not_sync_select && sync_ok(ctrl2_reg.source_select)
			&& source_events[ctrl2_reg.source_select];
		match_p = mode_reg != CCC_MODE_OFF && cnt_m == pri_m;
		match_s = mode_reg != CCC_MODE_OFF && cnt_m == sec_m;
		wrap = cnt_m == per_m;
		period_start = mode_reg != CCC_MODE_OFF && !hold_zero && (wrap || sync_hit);
		if (mode_reg == CCC_MODE_OFF || hold_zero || sync_hit) begin
			cnt_next = 32'h00000000;
		end else if (wrap) begin
			cnt_next = 32'h00000000;
		end else begin
			cnt_next = (cnt_m + 32'h00000001) & mask;
		end
		// trigger running flag: hardware set wins over any clear
		trig_set = ctrl2_reg.trigger_not_sync_select && sel_event && !ctrl2_reg.trigger_running_flag;
		if (autoclr_reg && match_s && ctrl2_reg.trigger_running_flag) begin
			ctrl2_next.trigger_running_flag = 1'b0;
		end
		if (trig_set) begin
			ctrl2_next.trigger_running_flag = 1'b1;
		end
		// compare output shaping per mode
		mode_seen_next = mode_reg;
		raw_next = raw_reg;
		done_next = done_reg;
		if (mode_seen_reg != mode_reg) begin
			raw_next = mode_reg == CCC_MODE_SS_LOW;
			done_next = 1'b0;
		end else begin
			case (mode_reg)
				CCC_MODE_OFF: raw_next = 1'b0;
				CCC_MODE_SS_HIGH: if (match_p && !done_reg) begin
					raw_next = 1'b1;
					done_next = 1'b1;
				end
				CCC_MODE_SS_LOW: if (match_p && !done_reg) begin
					raw_next = 1'b0;
					done_next = 1'b1;
				end
				CCC_MODE_TOGGLE: if (match_p) raw_next = !raw_reg;
				CCC_MODE_DUAL_SS: if (!done_reg) begin
					if (match_s && raw_reg) begin
						raw_next = 1'b0;
						done_next = 1'b1;
					end else if (match_p) begin
						raw_next = 1'b1;
					end
				end
				CCC_MODE_DUAL_CONT: if (match_s && raw_reg) raw_next = 1'b0; else if (match_p) raw_next = 1'b1;
				CCC_MODE_PWM_EDGE, CCC_MODE_PWM_CENTER: raw_next = (cnt_next & mask) < pri_m;
				default: raw_next = 1'b0;
			endcase
		end
		// fine delay shadow
		delay_act_next = (!pwm || period_start) ? ctrl2_reg.edge_fine_delay : delay_act_reg;
		delay_eff = mode_reg == CCC_MODE_SS_HIGH ? 2'h0 : delay_act_reg;
		// fault handling
		fault_cond = fault_en_reg && fault_a_in && pwm;
		fault_flag_next = fault_flag_reg;
		fault_active_next = fault_active_reg;
		if (fault_active_reg && !fault_a_in) begin
			if (ctrl2_reg.fault_hold_select) begin
				if (fault_clr_wr || !fault_flag_reg) begin
					fault_active_next = 1'b0;
					fault_flag_next = 1'b0;
				end
			end else if (period_start) begin
				fault_active_next = 1'b0;
				fault_flag_next = 1'b0;
			end
		end
		if (fault_cond) begin
			fault_active_next = 1'b1;
			fault_flag_next = fault_flag_reg || mode_reg == CCC_MODE_PWM_CENTER;
		end
		if (!pwm) begin
			fault_active_next = 1'b0;
		end
		// pin: invert after the fine delay so the delay lands on the rising edge when inverted
		if (fault_active_reg) begin
			pin_next = ctrl2_reg.fault_drive_level;
			phase_next = 2'h0;
		end else begin
			pin_next = fine_level ^ ctrl2_reg.output_invert;
			phase_next = fine_phase;
		end
		oe_next = !ctrl2_reg.pin_float_select;
		if (fault_active_reg && ctrl2_reg.fault_force_drive) begin
			oe_next = 1'b1;
		end
		// interrupts: hardware set wins over write-one-to-clear
		events = '0;
		events[CCC_IRQ_MATCH] = match_p;
		events[CCC_IRQ_PERIOD] = period_start;
		events[CCC_IRQ_FAULT] = fault_cond && !fault_active_reg;
		events[CCC_IRQ_TRIGGER] = trig_set;
		irq_status_next = irq_status_reg;
		if (wr_en && wr_reg.addr == CCC_OFS_IRQ_STATUS) begin
			irq_status_next = irq_status_reg & ~wval[CCC_IRQ_W-1:0];
		end
		irq_status_next = irq_status_next | events;
		irq_next = |(irq_status_reg & irq_mask_reg);
		period_ev_next = period_start;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl2_reg <= ccc_ctrl2_type'(CCC_CTRL2_RESET);
			mode_reg <= CCC_MODE_OFF;
			mode_seen_reg <= CCC_MODE_OFF;
			autoclr_reg <= 1'b0;
			fault_en_reg <= 1'b0;
			primary_reg <= CCC_WORD_RESET;
			secondary_reg <= CCC_WORD_RESET;
			period_reg <= {16'h0000, CCC_PERIOD_RESET};
			cnt_reg <= CCC_WORD_RESET;
			raw_reg <= 1'b0;
			done_reg <= 1'b0;
			fault_active_reg <= 1'b0;
			fault_flag_reg <= 1'b0;
			delay_act_reg <= 2'h0;
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			pin_reg <= 1'b0;
			oe_reg <= 1'b0;
			phase_reg <= 2'h0;
			irq_reg <= 1'b0;
			period_ev_reg <= 1'b0;
		end else begin
			ctrl2_reg <= ctrl2_next;
			mode_reg <= mode_next;
			mode_seen_reg <= mode_seen_next;
			autoclr_reg <= autoclr_next;
			fault_en_reg <= fault_en_next;
			primary_reg <= primary_next;
			secondary_reg <= secondary_next;
			period_reg <= period_next;
			cnt_reg <= cnt_next;
			raw_reg <= raw_next;
			done_reg <= done_next;
			fault_active_reg <= fault_active_next;
			fault_flag_reg <= fault_flag_next;
			delay_act_reg <= delay_act_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
			phase_reg <= phase_next;
			irq_reg <= irq_next;
			period_ev_reg <= period_ev_next;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign compare_output_pin_out = pin_reg;
	assign compare_output_pin_oe = oe_reg;
	assign edge_phase = phase_reg;
	assign period_event = period_ev_reg;
	assign irq = irq_reg;

endmodule : ccc_channel

// file: dv/ccc_src_model.sv
module ccc_src_model
	import ccc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fire_req,
	input wire logic [4:0] fire_code,
	input wire logic fault_req,
	output logic [31:0] source_events,
	output logic fault_a_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// pulse of the chosen source, fault follows request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			source_events <= 32'h00000000;
			fault_a_in <= 1'b0;
		end else begin
			source_events <= fire_req ? (32'h00000001 << fire_code) : 32'h00000000;
			fault_a_in <= fault_req;
		end
	end
endmodule : ccc_src_model

// file: dv/ccc_channel_asserts.sv
module ccc_channel_chk
	import ccc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [CCC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fault_a_in,
	input wire logic compare_output_pin_out,
	input wire logic compare_output_pin_oe,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] c2_reg;
	logic [15:0] c1_reg;
	logic [2:0] q_reg;
	logic w_hs;
	logic flt;
	assign w_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign flt = fault_a_in && c1_reg[4] && (c1_reg[2:1] == 2'b11);
	// control shadows, cycles since write or fault change
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c2_reg <= CCC_CTRL2_RESET;
			c1_reg <= 16'h0000;
			q_reg <= 3'h0;
		end else begin
			q_reg <= (w_hs || $changed(fault_a_in)) ? 3'h0 : ((q_reg == 3'h7) ? q_reg : q_reg + 3'h1);
			if (w_hs && s_axi_awaddr == CCC_OFS_CTRL2) c2_reg <= s_axi_wdata[15:0];
			if (w_hs && s_axi_awaddr == CCC_OFS_CTRL1) c1_reg <= s_axi_wdata[15:0];
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_write_answer; w_hs |-> ##2 s_axi_bvalid; endproperty
	a_write_answer: assert property (p_write_answer) else $error("no write response");
	property p_bresp_map; w_hs && s_axi_awaddr > 8'h1C |-> ##2 s_axi_bresp == CCC_RESP_SLVERR; endproperty
	a_bresp_map: assert property (p_bresp_map) else $error("unmapped write not refused");
	property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
	property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");
	property p_read_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_read_refused: assert property (p_read_refused) else $error("read accepted while busy");
	property p_reset_quiet; $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !compare_output_pin_oe; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
	property p_fault_level; q_reg >= 3'h5 && flt |-> compare_output_pin_out == c2_reg[14]; endproperty
	a_fault_level: assert property (p_fault_level) else $error("fault level wrong");
	property p_fault_drive; q_reg >= 3'h5 && flt && c2_reg[13] |-> compare_output_pin_oe; endproperty
	a_fault_drive: assert property (p_fault_drive) else $error("pin not driven in fault");
	property p_float; q_reg >= 3'h3 && c2_reg[5] && !c2_reg[13] |-> !compare_output_pin_oe; endproperty
	a_float: assert property (p_float) else $error("floated pin driven");
endmodule : ccc_channel_chk

bind ccc_channel ccc_channel_chk u_ccc_channel_chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .fault_a_in(fault_a_in), .compare_output_pin_out(compare_output_pin_out),
	.compare_output_pin_oe(compare_output_pin_oe), .irq(irq));

// file: dv/ccc_channel_tb.sv
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module ccc_channel_tb
	import ccc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, source_events, rv, v0, v1, rnd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, fire_req = 1'b0, fault_req = 1'b0, fault_a_in;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, pin_out, pin_oe;
	logic [1:0] s_axi_bresp, s_axi_rresp, edge_phase;
	logic period_event;
	logic [4:0] fire_code = 5'h00;
	logic [65:0] note;
	logic [65:0] rq[$];
	logic [1:0] bq[$];
	logic [4:0] codes[19] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h0A,
		5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C};
	int n_fail = 0, checked = 0, seed = 13;
	ccc_channel #(.SELF_CODE(5'h05)) u_ccc_channel (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .source_events(source_events),
		.fault_a_in(fault_a_in), .compare_output_pin_out(pin_out), .compare_output_pin_oe(pin_oe),
		.edge_phase(edge_phase), .period_event(period_event), .irq(irq));
	ccc_src_model u_ccc_src_model (.aclk(aclk), .aresetn(aresetn), .fire_req(fire_req),
		.fire_code(fire_code), .fault_req(fault_req), .source_events(source_events), .fault_a_in(fault_a_in));
	initial forever #25 aclk = ~aclk;
	task automatic test_done;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		bq.push_back(er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] m, input logic [31:0] e,
		output logic [31:0] d);
		@(posedge aclk);
		rq.push_back({er, m, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, CCC_RESP_OKAY, m, e, rv);
	endtask : rdc
	task automatic fire(input logic [4:0] c);
		@(posedge aclk);
		fire_req <= 1'b1;
		fire_code <= c;
		@(posedge aclk);
		fire_req <= 1'b0;
	endtask : fire
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			note[1:0] = bq.pop_front();
			`CHK(s_axi_bresp, note[1:0])
		end
		if (s_axi_rvalid && s_axi_rready) begin
			note = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata & note[63:32]}, {note[65:64], note[31:0]})
		end
	end
	initial begin
		#(50 * 30000);
		n_fail++;
		test_done();
	end
	initial begin
		cyc(3);
		aresetn <= 1'b1;
		rdc(CCC_OFS_CTRL2, 32'hFFFFFFFF, {16'h0000, CCC_CTRL2_RESET});
		rdc(CCC_OFS_PERIOD, 32'hFFFFFFFF, {16'h0000, CCC_PERIOD_RESET});
		rdc(CCC_OFS_CTRL1, 32'hFFFFFFFF, CCC_WORD_RESET);
		rd(8'h40, CCC_RESP_SLVERR, 32'hFFFFFFFF, 32'h0, rv);
		wr(8'h40, 32'hFFFFFFFF, CCC_RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			wr(CCC_OFS_CTRL2, {16'h0000, rnd[15:0]}, CCC_RESP_OKAY);
			rdc(CCC_OFS_CTRL2, 32'hFFFFFFFF, {16'h0000, rnd[15:0] & 16'hF7FF});
		end
		$display("test reset and control word done");
		wr(CCC_OFS_CTRL1, {29'h0, CCC_MODE_PWM_EDGE}, CCC_RESP_OKAY);
		foreach (codes[k]) begin
			wr(CCC_OFS_CTRL2, {27'h0, codes[k]}, CCC_RESP_OKAY);
			cyc(20);
			rd(CCC_OFS_COUNTER, CCC_RESP_OKAY, 32'h0, 32'h0, v0);
			fire(codes[k]);
			rd(CCC_OFS_COUNTER, CCC_RESP_OKAY, 32'h0, 32'h0, v1);
			`CHK(v1 < v0, k < 9)
		end
		$display("test sync sources done");
		foreach (codes[k]) begin
			wr(CCC_OFS_CTRL2, {24'h0, 3'h4, codes[k]}, CCC_RESP_OKAY);
			rdc(CCC_OFS_COUNTER, 32'hFFFFFFFF, 32'h0);
			fire(codes[k]);
			rdc(CCC_OFS_CTRL2, 32'h40, 32'h40);
		end
		wr(CCC_OFS_SECONDARY, 32'h20, CCC_RESP_OKAY);
		wr(CCC_OFS_CTRL1, 32'h0E, CCC_RESP_OKAY);
		wr(CCC_OFS_CTRL2, 32'h8B, CCC_RESP_OKAY);
		fire(5'h0B);
		cyc(60);
		rdc(CCC_OFS_CTRL2, 32'h40, 32'h0);
		rdc(CCC_OFS_COUNTER, 32'hFFFFFFFF, 32'h0);
		$display("test trigger done");
		wr(CCC_OFS_PERIOD, 32'h0F, CCC_RESP_OKAY);
		wr(CCC_OFS_CTRL1, 32'h17, CCC_RESP_OKAY);
		wr(CCC_OFS_CTRL2, 32'h6020, CCC_RESP_OKAY);
		wr(CCC_OFS_IRQ_MASK, 32'h4, CCC_RESP_OKAY);
		fault_req <= 1'b1;
		cyc(6);
		rdc(CCC_OFS_CTRL1, 32'h20, 32'h20);
		`CHK(pin_out, 1'b1)
		`CHK(pin_oe, 1'b1)
		`CHK(irq, 1'b1)
		fault_req <= 1'b0;
		cyc(40);
		rdc(CCC_OFS_CTRL1, 32'h20, 32'h0);
		wr(CCC_OFS_IRQ_STATUS, 32'hF, CCC_RESP_OKAY);
		wr(CCC_OFS_IRQ_MASK, 32'h0, CCC_RESP_OKAY);
		cyc(3);
		`CHK(irq, 1'b0)
		wr(CCC_OFS_CTRL2, 32'h8020, CCC_RESP_OKAY);
		fault_req <= 1'b1;
		cyc(6);
		`CHK(pin_out, 1'b0)
		`CHK(pin_oe, 1'b0)
		`CHK(irq, 1'b0)
		wr(CCC_OFS_IRQ_MASK, 32'h4, CCC_RESP_OKAY);
		cyc(3);
		`CHK(irq, 1'b1)
		fault_req <= 1'b0;
		cyc(40);
		rdc(CCC_OFS_CTRL1, 32'h20, 32'h20);
		wr(CCC_OFS_CTRL1, 32'h117, CCC_RESP_OKAY);
		cyc(4);
		rdc(CCC_OFS_CTRL1, 32'h20, 32'h0);
		wr(CCC_OFS_IRQ_STATUS, 32'hF, CCC_RESP_OKAY);
		cyc(3);
		`CHK(irq, 1'b0)
		wr(CCC_OFS_CTRL1, 32'h0, CCC_RESP_OKAY);
		wr(CCC_OFS_CTRL2, 32'h1000, CCC_RESP_OKAY);
		cyc(4);
		`CHK(pin_out, 1'b1)
		$display("test fault and interrupt done");
		test_done();
	end
endmodule : ccc_channel_tb
